// >>> rtl/ptm_pkg.sv
// Constants and types for the interrupt source and timer pin multiplexer.
package ptm_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam int LINES = 8;
	localparam int FIRST_LINE = 8;

	localparam logic [ADDR_W-1:0] OFS_SRC_HI_A = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_SRC_HI_B = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_FLASH_REMAP = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_TIMER_REMAP = 12'h00c;

	localparam int SRC_FIELD_BITS = 16;
	localparam int FLASH_EN_BIT = 21;
	localparam int T9_LSB = 0;
	localparam int T10_LSB = 4;
	localparam int T11_LSB = 8;

	localparam logic [SEL_W-1:0] CODE_PORT_A = 4'h0;
	localparam logic [SEL_W-1:0] CODE_PORT_B = 4'h1;
	localparam logic [SEL_W-1:0] CODE_PORT_C = 4'h2;
	localparam logic [SEL_W-1:0] CODE_PORT_D = 4'h3;
	localparam logic [SEL_W-1:0] CODE_PORT_F = 4'h4;
	localparam logic [SEL_W-1:0] CODE_TIM_DEF = 4'h0;
	localparam logic [SEL_W-1:0] CODE_TIM_ALT = 4'h1;

	localparam logic [SRC_FIELD_BITS-1:0] SRC_RST = 16'h0000;
	localparam logic [SEL_W-1:0] TIM_RST = 4'h0;
	localparam logic FLASH_RST = 1'b0;

	typedef struct packed {
		logic [15:0] pf;
		logic [15:0] pd;
		logic [15:0] pc;
		logic [15:0] pb;
		logic [15:0] pa;
	} ptm_ports_t;

	typedef struct packed {
		logic t9_ch1;
		logic t9_ch2;
		logic t10_ch1;
		logic t11_ch1;
	} ptm_tim_ch_t;

	typedef struct packed {
		logic pa2;
		logic pa3;
		logic pb14;
		logic pb15;
		logic pb8;
		logic pa6;
		logic pb9;
		logic pa7;
	} ptm_tim_pin_t;

	typedef struct packed {
		logic [SRC_FIELD_BITS-1:0] src_a;
		logic [SRC_FIELD_BITS-1:0] src_b;
		logic flash_en;
		logic [SEL_W-1:0] t9_sel;
		logic [SEL_W-1:0] t10_sel;
		logic [SEL_W-1:0] t11_sel;
		logic [LINES-1:0] irq;
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
		ptm_tim_pin_t pin_val;
		ptm_tim_pin_t pin_oe;
		ptm_tim_ch_t cap;
	} ptm_state_t;

	localparam ptm_state_t STATE_RST = '{
		src_a: SRC_RST,
		src_b: SRC_RST,
		flash_en: FLASH_RST,
		t9_sel: TIM_RST,
		t10_sel: TIM_RST,
		t11_sel: TIM_RST,
		irq: 8'h00,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h0000_0000,
		pin_val: 8'h00,
		pin_oe: 8'h00,
		cap: 4'h0
	};

endpackage

// >>> rtl/ptm_sync2.sv
// Two flip-flop level synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module ptm_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;
endmodule // ptm_sync2

// >>> rtl/ptm_mux.sv
// Register file and routing for interrupt lines 8 to 15, flash enable and small timer pins.
`timescale 1ns/1ps
module ptm_mux (
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ptm_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [ptm_pkg::DATA_W-1:0] PWDATA_IN,
	output logic [ptm_pkg::DATA_W-1:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire ptm_pkg::ptm_ports_t PORTS_IN,
	input wire ptm_pkg::ptm_tim_ch_t TIMER_CH_IN,
	output ptm_pkg::ptm_tim_pin_t TIMER_PIN_VAL_OUT,
	output ptm_pkg::ptm_tim_pin_t TIMER_PIN_OE_OUT,
	output ptm_pkg::ptm_tim_ch_t TIMER_CAP_OUT,
	output logic [ptm_pkg::LINES-1:0] IRQ_LINE_OUT,
	output logic EXT_FLASH_PORT_ENABLE_OUT
);
	import ptm_pkg::*;

	ptm_state_t s_r;
	ptm_state_t s_nxt;
	ptm_ports_t ports_sync;

	// Pin levels are asynchronous to the system clock.
	ptm_sync2 #(
		.W($bits(ptm_ports_t))
	) u_sync (
		.clk_in(CLK_SYS_IN),
		.rst_in(RESET_IN),
		.d_in(PORTS_IN),
		.q_out(ports_sync)
	);

	// Picks pin number pin of the port that code names; reserved codes give zero.
	function automatic logic pick_pin(
		input ptm_ports_t p,
		input logic [SEL_W-1:0] code,
		input int pin
	);
		logic lvl;
		lvl = 1'b0;
		unique case (code)
			CODE_PORT_A: lvl = p.pa[pin];
			CODE_PORT_B: lvl = p.pb[pin];
			CODE_PORT_C: lvl = p.pc[pin];
			CODE_PORT_D: lvl = p.pd[pin];
			CODE_PORT_F: lvl = p.pf[pin];
			default: lvl = 1'b0;
		endcase
		return lvl;
	endfunction

	logic setup_ph;
	logic access_ph;
	logic wr_commit;
	logic [SRC_FIELD_BITS*2-1:0] sel_all;
	logic [SEL_W-1:0] sel_code;

	assign setup_ph = PSEL_IN && !PENABLE_IN;
	assign access_ph = PSEL_IN && PENABLE_IN && s_r.pready;
	assign wr_commit = access_ph && PWRITE_IN && !s_r.pslverr;

	always_comb begin
		s_nxt = s_r;
		sel_all = {s_r.src_b, s_r.src_a};
		sel_code = '0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;

		// A setup cycle prepares the answer, which stands for exactly one access cycle.
		if (setup_ph) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = '0;
			unique case (PADDR_IN)
				OFS_SRC_HI_A: begin
					s_nxt.prdata[SRC_FIELD_BITS-1:0] = s_r.src_a;
				end
				OFS_SRC_HI_B: begin
					s_nxt.prdata[SRC_FIELD_BITS-1:0] = s_r.src_b;
				end
				OFS_FLASH_REMAP: begin
					s_nxt.prdata[FLASH_EN_BIT] = s_r.flash_en;
				end
				OFS_TIMER_REMAP: begin
					s_nxt.prdata[T9_LSB+:SEL_W] = s_r.t9_sel;
					s_nxt.prdata[T10_LSB+:SEL_W] = s_r.t10_sel;
					s_nxt.prdata[T11_LSB+:SEL_W] = s_r.t11_sel;
				end
				default: begin
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end

		// Reserved bits are not stored, so they always read back as zero.
		if (wr_commit) begin
			unique case (PADDR_IN)
				OFS_SRC_HI_A: begin
					s_nxt.src_a = PWDATA_IN[SRC_FIELD_BITS-1:0];
				end
				OFS_SRC_HI_B: begin
					s_nxt.src_b = PWDATA_IN[SRC_FIELD_BITS-1:0];
				end
				OFS_FLASH_REMAP: begin
					s_nxt.flash_en = PWDATA_IN[FLASH_EN_BIT];
				end
				OFS_TIMER_REMAP: begin
					s_nxt.t9_sel = PWDATA_IN[T9_LSB+:SEL_W];
					s_nxt.t10_sel = PWDATA_IN[T10_LSB+:SEL_W];
					s_nxt.t11_sel = PWDATA_IN[T11_LSB+:SEL_W];
				end
				default: begin
				end
			endcase
		end

		// Each line follows pin (line number) of the selected port, from the current registers.
		for (int i = 0; i < LINES; i++) begin
			sel_code = sel_all[i*SEL_W+:SEL_W];
			s_nxt.irq[i] = pick_pin(ports_sync, sel_code, FIRST_LINE + i);
		end

		// Timer nine drives both channels on the pair its code names.
		s_nxt.pin_val = '0;
		s_nxt.pin_oe = '0;
		s_nxt.cap = '0;
		unique case (s_r.t9_sel)
			CODE_TIM_DEF: begin
				s_nxt.pin_val.pa2 = TIMER_CH_IN.t9_ch1;
				s_nxt.pin_val.pa3 = TIMER_CH_IN.t9_ch2;
				s_nxt.pin_oe.pa2 = 1'b1;
				s_nxt.pin_oe.pa3 = 1'b1;
				s_nxt.cap.t9_ch1 = ports_sync.pa[2];
				s_nxt.cap.t9_ch2 = ports_sync.pa[3];
			end
			CODE_TIM_ALT: begin
				s_nxt.pin_val.pb14 = TIMER_CH_IN.t9_ch1;
				s_nxt.pin_val.pb15 = TIMER_CH_IN.t9_ch2;
				s_nxt.pin_oe.pb14 = 1'b1;
				s_nxt.pin_oe.pb15 = 1'b1;
				s_nxt.cap.t9_ch1 = ports_sync.pb[14];
				s_nxt.cap.t9_ch2 = ports_sync.pb[15];
			end
			default: begin
			end
		endcase

		unique case (s_r.t10_sel)
			CODE_TIM_DEF: begin
				s_nxt.pin_val.pb8 = TIMER_CH_IN.t10_ch1;
				s_nxt.pin_oe.pb8 = 1'b1;
				s_nxt.cap.t10_ch1 = ports_sync.pb[8];
			end
			CODE_TIM_ALT: begin
				s_nxt.pin_val.pa6 = TIMER_CH_IN.t10_ch1;
				s_nxt.pin_oe.pa6 = 1'b1;
				s_nxt.cap.t10_ch1 = ports_sync.pa[6];
			end
			default: begin
			end
		endcase

		unique case (s_r.t11_sel)
			CODE_TIM_DEF: begin
				s_nxt.pin_val.pb9 = TIMER_CH_IN.t11_ch1;
				s_nxt.pin_oe.pb9 = 1'b1;
				s_nxt.cap.t11_ch1 = ports_sync.pb[9];
			end
			CODE_TIM_ALT: begin
				s_nxt.pin_val.pa7 = TIMER_CH_IN.t11_ch1;
				s_nxt.pin_oe.pa7 = 1'b1;
				s_nxt.cap.t11_ch1 = ports_sync.pa[7];
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign PRDATA_OUT = s_r.prdata;
	assign PREADY_OUT = s_r.pready;
	assign PSLVERR_OUT = s_r.pslverr;
	assign IRQ_LINE_OUT = s_r.irq;
	assign EXT_FLASH_PORT_ENABLE_OUT = s_r.flash_en;
	assign TIMER_PIN_VAL_OUT = s_r.pin_val;
	assign TIMER_PIN_OE_OUT = s_r.pin_oe;
	assign TIMER_CAP_OUT = s_r.cap;
endmodule // ptm_mux

// >>> dv/ptm_mux_asserts.sv
// Concurrent checks on the register bus, flash enable and interrupt line outputs of the multiplexer.
`timescale 1ns/1ps
module ptm_mux_asserts (
	input wire logic CLK_SYS_IN,
	input wire logic RESET_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ptm_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [ptm_pkg::DATA_W-1:0] PWDATA_IN,
	input wire logic [ptm_pkg::DATA_W-1:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire ptm_pkg::ptm_ports_t PORTS_IN,
	input wire logic [ptm_pkg::LINES-1:0] IRQ_LINE_OUT,
	input wire logic EXT_FLASH_PORT_ENABLE_OUT
);
	import ptm_pkg::*;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (RESET_IN);
	wire rd = PREADY_OUT && !PWRITE_IN;
	wire fw = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == OFS_FLASH_REMAP;
	rdy_after_setup_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
		else $error("no ready after setup");
	rdy_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready longer than one cycle");
	err_map_a: assert property (PREADY_OUT |-> PSLVERR_OUT == (|PADDR_IN[11:4] || |PADDR_IN[1:0]))
		else $error("error flag wrong for address");
	flash_wr_a: assert property (fw |=> EXT_FLASH_PORT_ENABLE_OUT == $past(PWDATA_IN[21]))
		else $error("flash enable not written");
	flash_hold_a: assert property (!fw |=> $stable(EXT_FLASH_PORT_ENABLE_OUT))
		else $error("flash enable moved without write");
	flash_rd_a: assert property (rd && PADDR_IN == OFS_FLASH_REMAP |->
		PRDATA_OUT == {10'h000, EXT_FLASH_PORT_ENABLE_OUT, 21'h000000})
		else $error("flash register read wrong");
	src_rsv_a: assert property (rd && PADDR_IN[11:3] == 9'h000 |-> PRDATA_OUT[31:16] == 16'h0000)
		else $error("reserved source bits read nonzero");
	irq_quiet_a: assert property ((PORTS_IN == '0) [*4] |-> IRQ_LINE_OUT == '0)
		else $error("line high with all pins low");
	rst_clear_a: assert property (disable iff (1'b0) RESET_IN |=>
		!PREADY_OUT && !EXT_FLASH_PORT_ENABLE_OUT && IRQ_LINE_OUT == '0)
		else $error("outputs not cleared by reset");
	cover property (fw);
	cover property (PSLVERR_OUT);
	cover property (|IRQ_LINE_OUT);
endmodule // ptm_mux_asserts

bind ptm_mux ptm_mux_asserts i_ptm_mux_asserts (.*);

// >>> dv/ptm_mux_bench.sv
// Self-checking bench for the interrupt source and timer pin multiplexer.
`timescale 1ns/1ps
module ptm_mux_bench;
	import ptm_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic pen = 0;
	logic pwr = 0;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0;
	logic [31:0] prd, rd, d;
	logic prdy, perr, flash;
	ptm_ports_t ports = '0;
	ptm_tim_ch_t ch = '0;
	ptm_tim_pin_t val, oe;
	logic [7:0] irq, eirq, eoe;
	logic [3:0] cd, cap, ecap;
	logic [31:0] m[4] = '{default: 0};
	logic [31:0] mk[4] = '{32'hffff, 32'hffff, 32'h20_0000, 32'hfff};
	int n_fail = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	ptm_mux i_ptm_mux (.CLK_SYS_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
		.PSLVERR_OUT(perr), .PORTS_IN(ports), .TIMER_CH_IN(ch), .TIMER_PIN_VAL_OUT(val),
		.TIMER_PIN_OE_OUT(oe), .TIMER_CAP_OUT(cap), .IRQ_LINE_OUT(irq),
		.EXT_FLASH_PORT_ENABLE_OUT(flash));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
		int k;
		k = 0;
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= dat;
		@(posedge clk);
		pen <= 1;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			finish_test();
		end
		rd = prd;
		chk(32'(perr), 32'(a > 15));
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] dat);
		if (a < 16) m[a[3:2]] = dat & mk[a[3:2]];
		apb(1, a, a < 16 ? dat & mk[a[3:2]] : dat);
	endtask
	task automatic rd_all();
		for (int a = 0; a < 20; a += 4) begin
			apb(0, 12'(a), 0);
			chk(rd, a < 16 ? m[a / 4] : 32'h0);
		end
		chk(32'(flash), 32'(m[2][21]));
	endtask
	initial begin
		void'($urandom(5000));
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd_all();
		$display("test reset values done");
		for (int t = 0; t < 6; t++) begin
			for (int a = 0; a < 20; a += 4) wr(12'(a), $urandom);
			rd_all();
		end
		$display("test register access done");
		for (int t = 0; t < 8; t++) begin
			ports <= 80'({$urandom, $urandom, $urandom});
			for (int f = 0; f < 8; f++) d[4 * f +: 4] = 4'($urandom % 6);
			wr(12'h000, d);
			wr(12'h004, d >> 16);
			repeat (4) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				cd = m[i / 4][4 * (i % 4) +: 4];
				eirq[i] = cd < 5 ? ports[16 * cd + 8 + i] : 1'b0;
			end
			chk(32'(irq), 32'(eirq));
		end
		$display("test interrupt routing done");
		for (int t = 0; t < 9; t++) begin
			ch <= 4'($urandom);
			d = {20'h0, 4'($urandom % 3), 4'((t / 3) % 3), 4'(t % 3)};
			wr(12'h00c, d);
			repeat (3) @(posedge clk);
			eoe = {{2{d[3:0] == 0}}, {2{d[3:0] == 1}}, d[7:4] == 0, d[7:4] == 1,
				d[11:8] == 0, d[11:8] == 1};
			chk(32'(oe), 32'(eoe));
			chk(32'(val), 32'({ch[3], ch[2], ch[3], ch[2], ch[1], ch[1], ch[0], ch[0]} & eoe));
			ecap[3] = d[3:0] == 0 ? ports.pa[2] : (d[3:0] == 1 ? ports.pb[14] : 1'b0);
			ecap[2] = d[3:0] == 0 ? ports.pa[3] : (d[3:0] == 1 ? ports.pb[15] : 1'b0);
			ecap[1] = d[7:4] == 0 ? ports.pb[8] : (d[7:4] == 1 ? ports.pa[6] : 1'b0);
			ecap[0] = d[11:8] == 0 ? ports.pb[9] : (d[11:8] == 1 ? ports.pa[7] : 1'b0);
			chk(32'(cap), 32'(ecap));
		end
		$display("test timer routing done");
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		m = '{default: 0};
		@(posedge clk);
		rd_all();
		chk(32'(irq), 32'(ports.pa[15:8]));
		chk(32'(oe), 32'h0000_00ca);
		$display("test second reset done");
		finish_test();
	end
endmodule // ptm_mux_bench
